// ---- design/bpcs_pkg.sv ----
package bpcs_pkg;

  // Dword offset of the combined command and status word
  localparam logic [7:0] BPCS_CMD_STAT_OFS = 8'h04;

  // Command field positions
  localparam int BPCS_CMD_IO_BIT = 0;
  localparam int BPCS_CMD_MEM_BIT = 1;
  localparam int BPCS_CMD_BME_BIT = 2;
  localparam int BPCS_CMD_PAL_BIT = 5;
  localparam int BPCS_CMD_PERR_BIT = 6;
  localparam int BPCS_CMD_SERR_BIT = 8;
  localparam int BPCS_CMD_FB2B_BIT = 9;

  // Writable command bits; bits 3, 4, 7 and 15:10 read as zero
  localparam logic [15:0] BPCS_CMD_WMASK = 16'h0367;
  localparam logic [15:0] BPCS_CMD_RESET = 16'h0000;

  // Constant status bits: capability list, 66 MHz, fast b2b, medium select
  localparam logic [15:0] BPCS_STAT_CONST = 16'h02B0;

  // Sticky status flags, in the order of the flag vector
  localparam int BPCS_NFLAGS = 6;
  localparam int BPCS_FLAG_DPERR = 0;
  localparam int BPCS_FLAG_STA = 1;
  localparam int BPCS_FLAG_RTA = 2;
  localparam int BPCS_FLAG_RMA = 3;
  localparam int BPCS_FLAG_SSE = 4;
  localparam int BPCS_FLAG_DPE = 5;

  // Status-half bit position of each flag (bits 24, 27..31 of the dword)
  localparam int BPCS_FLAG_POS [BPCS_NFLAGS] = '{8, 11, 12, 13, 14, 15};

  // Palette addresses, compared on the low ten I/O address bits
  localparam int BPCS_PAL_AW = 10;
  localparam logic [9:0] BPCS_PAL_A0 = 10'h3C6;
  localparam logic [9:0] BPCS_PAL_A1 = 10'h3C8;
  localparam logic [9:0] BPCS_PAL_A2 = 10'h3C9;

endpackage

// ---- design/bpcs_sticky_flag.sv ----
`timescale 1ns/1ps

// One write-one-to-clear status flag
module bpcs_sticky_flag
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Hardware event and software clear
  input wire logic set_ev,
  input wire logic clr_wr,
  // Flag state
  output logic flag_q
);

  // Flag next state
  logic flag_d;

  // Set beats clear so an event in the clearing cycle is not lost
  assign flag_d = set_ev | (flag_q & ~clr_wr);

  // Flag register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      flag_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

endmodule

// ---- design/bpcs_top.sv ----
// How it works
// RQ1: Command bit 0 gates primary I/O claiming.
// RQ2: Command bit 1 gates primary memory claiming.
// RQ3: Bit 2 clear blocks mastering and secondary acceptance.
// RQ4: Bit 2 set allows forwarding as primary master.
// RQ5: Command bit 3 reads zero, read-only.
// RQ6: Command bit 4 reads zero, read-only.
// RQ7: Bit 5 snoops palette writes on ten bits.
// RQ8: Bit 6 selects normal parity error actions.
// RQ9: Bit 7 and bits 15:10 read zero.
// RQ10: Bit 8 enables the system error driver.
// RQ11: Bit 9 permits fast back-to-back mastering.
// RQ12: Status bit 20 reads one, capability list.
// RQ13: Status bit 21 reads one, 66 MHz.
// RQ14: Status bit 23 reads one, fast b2b.
// RQ15: Bit 24 latches master data parity error.
// RQ16: Bits 26:25 read 01, medium select timing.
// RQ17: Bit 27 latches signalled target abort.
// RQ18: Bit 28 latches received target abort.
// RQ19: Bit 29 latches received master abort.
// RQ20: Bit 30 latches system error driven.
// RQ21: Bit 31 latches any primary parity error.
// RQ22: Status bits 19:16 and 22 read zero.
// RQ23: Flags clear only by writing one.
// RQ24: Simultaneous set and clear: set wins.
`timescale 1ns/1ps

module bpcs_top
  import bpcs_pkg::*;
#(
  parameter int CFG_AW = 8
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration access from the primary bus
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [CFG_AW-1:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // Primary target decode requests
  input wire logic tgt_io_req,
  input wire logic tgt_mem_req,
  input wire logic tgt_io_wr,
  input wire logic [15:0] tgt_io_addr,
  output logic tgt_io_claim,
  output logic tgt_mem_claim,
  output logic tgt_pal_claim,
  // Forwarding master and secondary acceptance
  input wire logic mst_fwd_req,
  input wire logic sec_accept_req,
  output logic mst_fwd_go,
  output logic sec_accept_go,
  output logic mst_fb2b_en,
  // Parity handling
  output logic perr_resp_en,
  // Error events from the bus engines
  input wire logic ev_mst_data_perr,
  input wire logic ev_tgt_abort_sent,
  input wire logic ev_mst_tgt_abort,
  input wire logic ev_mst_mst_abort,
  input wire logic ev_any_perr,
  input wire logic serr_req,
  // Open-drain system error pin, active low
  output logic primary_system_error_out_n,
  output logic primary_system_error_oe,
  // Snapshot of the command word
  output logic [15:0] cmd_state
);

  // Command register
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  // Sticky status flags
  logic [BPCS_NFLAGS-1:0] flag_q;
  logic [BPCS_NFLAGS-1:0] flag_set;
  logic [BPCS_NFLAGS-1:0] flag_clr;
  // Assembled status half
  logic [15:0] stat_word;
  // Read path
  logic [31:0] rdata_d;
  // Decodes
  logic hit;
  logic wr_hit;
  logic pal_match;
  logic serr_drive;
  // Output registers
  logic tgt_io_claim_q;
  logic tgt_mem_claim_q;
  logic tgt_pal_claim_q;
  logic mst_fwd_go_q;
  logic sec_accept_go_q;
  logic serr_oe_q;
  logic [31:0] cfg_rdata_q;
  logic cfg_rvalid_q;

  // Palette compare on the low address bits only
  function automatic logic pal_hit(input logic [BPCS_PAL_AW-1:0] a);
    pal_hit = (a == BPCS_PAL_A0) || (a == BPCS_PAL_A1) || (a == BPCS_PAL_A2);
  endfunction

  // Register select; only one dword lives here
  assign hit = (cfg_addr == CFG_AW'(BPCS_CMD_STAT_OFS));
  assign wr_hit = cfg_wr & hit;

  // Command write with byte lanes 0 and 1
  // RQ5 RQ6 RQ9 masked bits
  // Read-only command bits never take a written one
  assign cmd_d[7:0] = (wr_hit && cfg_be[0]) ?
    (cfg_wdata[7:0] & BPCS_CMD_WMASK[7:0]) : cmd_q[7:0];
  assign cmd_d[15:8] = (wr_hit && cfg_be[1]) ?
    (cfg_wdata[15:8] & BPCS_CMD_WMASK[15:8]) : cmd_q[15:8];

  // Command register process
  // RQ1 RQ2 reset to zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cmd_q <= BPCS_CMD_RESET;
    end
    else
    begin
      cmd_q <= cmd_d;
    end
  end

  // Hardware events that set each flag
  // RQ15 master parity
  assign flag_set[BPCS_FLAG_DPERR] = ev_mst_data_perr;
  // RQ17 target abort sent
  assign flag_set[BPCS_FLAG_STA] = ev_tgt_abort_sent;
  // RQ18 target abort received
  assign flag_set[BPCS_FLAG_RTA] = ev_mst_tgt_abort;
  // RQ19 master abort received
  assign flag_set[BPCS_FLAG_RMA] = ev_mst_mst_abort;
  // RQ20 pin driven event
  // Flag follows the pin itself, so a masked request leaves it clear
  assign flag_set[BPCS_FLAG_SSE] = serr_drive;
  // RQ21 any parity error
  // Recorded regardless of the parity response enable
  assign flag_set[BPCS_FLAG_DPE] = ev_any_perr;

  // One sticky flag per status event, all cleared through lane 3
  genvar gi;
  generate
    for (gi = 0; gi < BPCS_NFLAGS; gi++)
    begin : g_flag
      // RQ23 write one clears
      // A zero written to the position leaves the flag alone
      assign flag_clr[gi] = wr_hit && cfg_be[2 + BPCS_FLAG_POS[gi] / 8] &&
        cfg_wdata[16 + BPCS_FLAG_POS[gi]];
      // RQ24 set beats clear
      bpcs_sticky_flag u_flag
      (
        .clk_sys(clk_sys),
        .rst(rst),
        .set_ev(flag_set[gi]),
        .clr_wr(flag_clr[gi]),
        .flag_q(flag_q[gi])
      );
    end
  endgenerate

  // Status half: constants plus sticky flags
  // RQ12 RQ13 RQ14 RQ16 constant bits
  // RQ22 reserved zeros
  // Reserved bits fall out as zero from the constant pattern
  always_comb
  begin
    stat_word = BPCS_STAT_CONST;
    for (int i = 0; i < BPCS_NFLAGS; i++)
    begin
      stat_word[BPCS_FLAG_POS[i]] = flag_q[i];
    end
  end

  // Read data: the dword when selected, zero elsewhere
  assign rdata_d = (cfg_rd && hit) ? {stat_word, cmd_q} : 32'h0000_0000;

  // Read answer register, one cycle after the request
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cfg_rdata_q <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
    end
    else
    begin
      cfg_rdata_q <= rdata_d;
      cfg_rvalid_q <= cfg_rd;
    end
  end

  // Palette snoop needs an I/O write with the snoop bit set
  // RQ7 palette decode
  // Upper address bits 15:10 are deliberately not compared
  assign pal_match = tgt_io_req && tgt_io_wr &&
    cmd_q[BPCS_CMD_PAL_BIT] && pal_hit(tgt_io_addr[BPCS_PAL_AW-1:0]);

  // System error drive needs both a request and the enable
  // RQ10 driver enable
  assign serr_drive = serr_req & cmd_q[BPCS_CMD_SERR_BIT];

  // Claim and grant registers; one cycle from request to answer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tgt_io_claim_q <= 1'b0;
      tgt_mem_claim_q <= 1'b0;
      tgt_pal_claim_q <= 1'b0;
      mst_fwd_go_q <= 1'b0;
      sec_accept_go_q <= 1'b0;
      serr_oe_q <= 1'b0;
    end
    else
    begin
      // RQ1 I/O claim gate
      tgt_io_claim_q <= tgt_io_req & cmd_q[BPCS_CMD_IO_BIT];
      // RQ2 memory claim gate
      tgt_mem_claim_q <= tgt_mem_req & cmd_q[BPCS_CMD_MEM_BIT];
      tgt_pal_claim_q <= pal_match;
      // RQ3 RQ4 master enable gate
      // Both directions hang on the same bit, so forwarding stops cleanly
      mst_fwd_go_q <= mst_fwd_req & cmd_q[BPCS_CMD_BME_BIT];
      sec_accept_go_q <= sec_accept_req & cmd_q[BPCS_CMD_BME_BIT];
      // RQ10 pin enable
      serr_oe_q <= serr_drive;
    end
  end

  // Outputs straight from flip-flops, except the error pin data, which is tied low
  assign tgt_io_claim = tgt_io_claim_q;
  assign tgt_mem_claim = tgt_mem_claim_q;
  assign tgt_pal_claim = tgt_pal_claim_q;
  assign mst_fwd_go = mst_fwd_go_q;
  assign sec_accept_go = sec_accept_go_q;
  // RQ11 fast back-to-back enable
  assign mst_fb2b_en = cmd_q[BPCS_CMD_FB2B_BIT];
  // RQ8 parity response
  // When low the engines may carry on past detected parity errors
  assign perr_resp_en = cmd_q[BPCS_CMD_PERR_BIT];
  // Open drain: data low whenever driven, enable does the work
  assign primary_system_error_out_n = 1'b0;
  assign primary_system_error_oe = serr_oe_q;
  assign cmd_state = cmd_q;
  assign cfg_rdata = cfg_rdata_q;
  assign cfg_rvalid = cfg_rvalid_q;

endmodule

// ---- tb/bpcs_asserts.sv ----
`timescale 1ns/1ps
module bpcs_chk
#(
  parameter int CFG_AW = 8
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Config port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [CFG_AW-1:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  // Decode and gates
  input wire logic tgt_io_req,
  input wire logic tgt_mem_req,
  input wire logic tgt_io_wr,
  input wire logic [15:0] tgt_io_addr,
  input wire logic tgt_io_claim,
  input wire logic tgt_mem_claim,
  input wire logic tgt_pal_claim,
  input wire logic mst_fwd_req,
  input wire logic mst_fwd_go,
  input wire logic mst_fb2b_en,
  input wire logic perr_resp_en,
  // Events and error pin
  input wire logic ev_tgt_abort_sent,
  input wire logic serr_req,
  input wire logic primary_system_error_oe,
  input wire logic [15:0] cmd_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Palette write hit; upper six address bits are ignored on purpose
  wire pal_hit = tgt_io_req && tgt_io_wr && cmd_state[5] &&
    (tgt_io_addr[9:0] inside {10'h3C6, 10'h3C8, 10'h3C9});
  // Read of the mapped dword
  wire rd_hit = cfg_rd && cfg_addr == CFG_AW'('h04);
  // Event, one quiet cycle with no write that could clear, then the read
  sequence abort_then_rd; ev_tgt_abort_sent ##1 !cfg_wr ##1 rd_hit; endsequence
  sequence serr_then_rd; serr_req && cmd_state[8] ##1 rd_hit; endsequence
  io_claim_a:
    assert property (1 |=> tgt_io_claim == ($past(tgt_io_req) && $past(cmd_state[0])))
    else $error("io claim wrong");
  mem_claim_a:
    assert property (1 |=> tgt_mem_claim == ($past(tgt_mem_req) && $past(cmd_state[1])))
    else $error("mem claim wrong");
  fwd_gate_a:
    assert property (1 |=> mst_fwd_go == ($past(mst_fwd_req) && $past(cmd_state[2])))
    else $error("forward gate wrong");
  pal_claim_a:
    assert property (1 |=> tgt_pal_claim == $past(pal_hit)) else $error("palette claim wrong");
  ro_zero_a:
    assert property ((cmd_state & 16'hFC98) == 16'h0000) else $error("read-only bit set");
  cmd_mirror_a:
    assert property (perr_resp_en == cmd_state[6] && mst_fb2b_en == cmd_state[9])
    else $error("command mirror wrong");
  serr_oe_a:
    assert property (1 |=> primary_system_error_oe == ($past(serr_req) && $past(cmd_state[8])))
    else $error("error driver wrong");
  stat_const_a:
    assert property (rd_hit |=> cfg_rvalid && (cfg_rdata[31:16] & 16'h06FF) == 16'h02B0)
    else $error("status constants wrong");
  abort_flag_a:
    assert property (abort_then_rd |=> cfg_rdata[27]) else $error("abort flag not set");
  serr_flag_a:
    assert property (serr_then_rd |=> cfg_rdata[30]) else $error("error flag not set");
endmodule
bind bpcs_top bpcs_chk #(.CFG_AW(CFG_AW)) u_chk (.*);

// ---- tb/bpcs_host.sv ----
`timescale 1ns/1ps
// Upstream host: one strobed config cycle at a time
module bpcs_host
(
  // Clock
  input wire logic clk_sys,
  // Config port towards the bridge
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  // Idle bus before the first cycle
  initial
  begin
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
  end
  // Clearing a flag only by a one in its lane
  // write one clears
  task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_sys);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, b, d};
    @(posedge clk_sys);
    // Released address and data show junk, not the old value; byte enables keep theirs
    {cfg_wr, cfg_addr, cfg_wdata} <= {1'b0, ~a, ~d};
  endtask
  // Read: answer stands for one cycle after the taking edge
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    {cfg_rd, cfg_addr} <= {1'b0, ~a};
    #1;
    d = cfg_rvalid ? cfg_rdata : 32'hDEAD_0BAD;
  endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  // Clock, reset and counters
  logic clk_sys = 0;
  logic rst = 1;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // Config port, driven by the host model
  logic cfg_wr, cfg_rd, cfg_rvalid;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rd_data;
  // Decode, gate and event inputs
  logic tgt_io_req = 0, tgt_mem_req = 0, tgt_io_wr = 0, mst_fwd_req = 0;
  logic sec_accept_req = 0, serr_req = 0;
  logic [15:0] tgt_io_addr = 16'h0000;
  logic [4:0] ev = 5'h00;
  wire ev_mst_data_perr = ev[0];
  wire ev_tgt_abort_sent = ev[1];
  wire ev_mst_tgt_abort = ev[2];
  wire ev_mst_mst_abort = ev[3];
  wire ev_any_perr = ev[4];
  // Outputs
  logic tgt_io_claim, tgt_mem_claim, tgt_pal_claim, mst_fwd_go, sec_accept_go;
  logic mst_fb2b_en, perr_resp_en, primary_system_error_out_n, primary_system_error_oe;
  logic [15:0] cmd_state;
  // Status bit of each event line, and palette probe addresses
  int fpos [5] = '{24, 27, 28, 29, 31};
  logic [15:0] pal [4] = '{16'hFFC6, 16'h03C8, 16'h7FC9, 16'h03C7};
  bpcs_top uut (.*);
  bpcs_host host (.*);
  always #5 clk_sys = ~clk_sys;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task rd_chk(input string n, input logic [31:0] e);
    host.rd(8'h04, rd_data);
    chk(n, e, rd_data);
  endtask
  // One-cycle event pulse
  task pulse(input logic [4:0] e);
    @(posedge clk_sys);
    ev <= e;
    @(posedge clk_sys);
    ev <= 5'h00;
  endtask
  // Reset image, lane writes, read-only bits, unmapped place
  task t_regs;
    rd_chk("reset", 32'h02B0_0000);
    host.wr(8'h04, 4'h3, 32'hFFFF_FFFF);
    rd_chk("cmd ro", 32'h02B0_0367);
    host.wr(8'h08, 4'hF, 32'h0000_0000);
    host.wr(8'h04, 4'h2, 32'h0000_0000);
    rd_chk("lane", 32'h02B0_0067);
    host.rd(8'h08, rd_data);
    chk("unmapped", 32'h0000_0000, rd_data);
    $display("regs done");
  endtask
  // Gated claims and grants for one command value
  task t_gates(input logic [15:0] c);
    host.wr(8'h04, 4'h3, {16'h0000, c});
    @(posedge clk_sys);
    {tgt_io_req, tgt_mem_req, mst_fwd_req, sec_accept_req, tgt_io_wr} <= 5'h1F;
    foreach (pal[i])
    begin
      @(posedge clk_sys);
      tgt_io_addr <= pal[i];
      @(posedge clk_sys);
      #1;
      chk("pal", 32'(c[5] && i < 3), 32'(tgt_pal_claim));
    end
    chk("gates", 32'({c[0], c[1], c[2], c[2], c[6], c[9]}), 32'({tgt_io_claim, tgt_mem_claim,
      mst_fwd_go, sec_accept_go, perr_resp_en, mst_fb2b_en}));
    @(posedge clk_sys);
    {tgt_io_req, tgt_mem_req, mst_fwd_req, sec_accept_req, tgt_io_wr} <= 5'h00;
    $display("gates done");
  endtask
  // Each event-line flag (all but bit 30): set, survives a zero write, cleared by a one
  task t_flags;
    foreach (fpos[i])
    begin
      pulse(5'h01 << i);
      rd_chk("set", 32'h02B0_0000 | (32'h1 << fpos[i]));
      host.wr(8'h04, 4'hC, 32'h0000_0000);
      rd_chk("kept", 32'h02B0_0000 | (32'h1 << fpos[i]));
      host.wr(8'h04, 4'hC, 32'h1 << fpos[i]);
      rd_chk("clear", 32'h02B0_0000);
    end
    fork
      host.wr(8'h04, 4'hC, 32'h0800_0000);
      pulse(5'h02);
    join
    rd_chk("set wins", 32'h0AB0_0000);
    $display("flags done");
  endtask
  // Error driver off, then on, and its flag
  task t_serr;
    @(posedge clk_sys);
    serr_req <= 1;
    @(posedge clk_sys);
    #1;
    chk("oe off", 32'h0, 32'(primary_system_error_oe));
    rd_chk("no flag", 32'h0AB0_0000);
    host.wr(8'h04, 4'h3, 32'h0000_0100);
    @(posedge clk_sys);
    #1;
    chk("oe on", 32'h1, 32'(primary_system_error_oe));
    chk("pin low", 32'h0, 32'(primary_system_error_out_n));
    @(posedge clk_sys);
    serr_req <= 0;
    rd_chk("flag", 32'h4AB0_0100);
    $display("serr done");
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, well above the roughly 130 cycles needed
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    t_regs();
    t_gates(16'h0367);
    t_gates(16'h0000);
    t_flags();
    t_serr();
    end_of_test();
  end
endmodule
